// ---- hw/mael_params.svh ----
`ifndef MAEL_PARAMS_SVH
`define MAEL_PARAMS_SVH

// Clock rate and persistence time in their own units.
`define MAEL_CLK_HZ 40000000
`define MAEL_PERSIST_MIN 5
`define MAEL_SEC_PER_MIN 60

// Counter and data widths.
`define MAEL_PCNT_W 34
`define MAEL_SEC_W 26
`define MAEL_MEAS_W 16
`define MAEL_TS_W 32
`define MAEL_NKIND 8
`define MAEL_NQUAL 7
`define MAEL_NCOMP 4
`define MAEL_PTR_W 7
`define MAEL_ADDR_W 9

// Compartment capacities and base addresses in the event store.
`define MAEL_DEPTH 350
`define MAEL_CAP0 100
`define MAEL_CAP1 100
`define MAEL_CAP2 100
`define MAEL_CAP3 50
`define MAEL_BASE0 0
`define MAEL_BASE1 100
`define MAEL_BASE2 200
`define MAEL_BASE3 300

// Default detection thresholds.
`define MAEL_V_MISS_TH 16'h2000
`define MAEL_V_OK_TH 16'h6000
`define MAEL_V_FEED_TH 16'h1000
`define MAEL_V_UNB_TH 16'h0800
`define MAEL_I_MIN_TH 16'h0100
`define MAEL_I_UNB_TH 16'h0400

`endif

// ---- hw/mael_pkg.sv ----
`include "mael_params.svh"

package mael_pkg;

	// Anomaly kinds; the order groups kinds by compartment.
	typedef enum logic [2:0] {
		MAEL_K_MISSPOT, MAEL_K_VUNB, MAEL_K_REV, MAEL_K_IUNB,
		MAEL_K_IABS, MAEL_K_FEED, MAEL_K_PWR, MAEL_K_TXN
	} mael_kind_t;

	typedef logic [2:0][`MAEL_MEAS_W-1:0] mael_tri_t;

	// One stored log entry.
	typedef struct packed {
		mael_kind_t kind;
		logic restore;
		logic snap_ok;
		logic [`MAEL_TS_W-1:0] ts;
		logic [31:0] dur;
		mael_tri_t v;
		mael_tri_t i;
		mael_tri_t pf;
	} mael_entry_t;

	// Whole state of the logger top.
	typedef struct packed {
		logic [1:0] aux_s1;
		logic [1:0] aux_s2;
		logic [`MAEL_NQUAL-1:0] qual;
		logic [`MAEL_NQUAL-1:0][`MAEL_PCNT_W-1:0] pcnt;
		logic [`MAEL_NKIND-1:0] pend_occ;
		logic [`MAEL_NKIND-1:0] pend_rst;
		logic [`MAEL_NKIND-1:0][`MAEL_TS_W-1:0] ts_occ;
		logic [`MAEL_NKIND-1:0][`MAEL_TS_W-1:0] ts_rst;
		logic [1:0][31:0] dur;
		logic [31:0] txn_code;
		logic [`MAEL_SEC_W-1:0] sec_div;
		logic [`MAEL_NCOMP-1:0][`MAEL_PTR_W-1:0] wp;
		logic [`MAEL_NCOMP-1:0][`MAEL_PTR_W-1:0] fill;
		logic [31:0] occ_cnt;
		logic rd_pend;
		logic rd_bad;
		logic rd_valid;
		logic rd_err;
		mael_entry_t rd_data;
	} mael_state_t;

	// Compartment that holds a kind.
	function automatic logic [1:0] mael_comp(input mael_kind_t k);
		case (k)
			MAEL_K_MISSPOT, MAEL_K_VUNB: mael_comp = 2'h0;
			MAEL_K_REV, MAEL_K_IUNB, MAEL_K_IABS: mael_comp = 2'h1;
			MAEL_K_FEED, MAEL_K_PWR: mael_comp = 2'h2;
			default: mael_comp = 2'h3;
		endcase
	endfunction

	// Capacity of a compartment.
	function automatic logic [8:0] mael_cap(input logic [1:0] c);
		case (c)
			2'h0: mael_cap = 9'(`MAEL_CAP0);
			2'h1: mael_cap = 9'(`MAEL_CAP1);
			2'h2: mael_cap = 9'(`MAEL_CAP2);
			default: mael_cap = 9'(`MAEL_CAP3);
		endcase
	endfunction

	// Base address of a compartment.
	function automatic logic [8:0] mael_base(input logic [1:0] c);
		case (c)
			2'h0: mael_base = 9'(`MAEL_BASE0);
			2'h1: mael_base = 9'(`MAEL_BASE1);
			2'h2: mael_base = 9'(`MAEL_BASE2);
			default: mael_base = 9'(`MAEL_BASE3);
		endcase
	endfunction

endpackage

// ---- hw/mael_log_ram.sv ----
`timescale 1ns/10ps
`include "mael_params.svh"

module mael_log_ram #(
	parameter int DEPTH = `MAEL_DEPTH,
	parameter int AW = `MAEL_ADDR_W,
	parameter int W = 8
) (
	// Clock.
	input wire logic mclk,
	// Write port.
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [W-1:0] wr_data,
	// Read port, data one cycle after the address.
	input wire logic [AW-1:0] rd_addr,
	output logic [W-1:0] rd_data
);

	logic [W-1:0] mem [DEPTH];

	// Refuse a depth that the address cannot reach.
	if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
		$error("mael_log_ram: DEPTH does not fit AW");
	end

	// Single write and registered read each cycle.
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule // mael_log_ram

// ---- hw/mael_top.sv ----
`timescale 1ns/10ps
`include "mael_params.svh"
////////////////////////////////////////////////////////////////////////
// How it works
// - Low voltage with live current: missing potential.
// - Swapped current terminals flag reversal, one or two.
// - Spread among phase voltages flags voltage unbalance.
// - Current unbalance checked only under valid conditions.
// - Low current with good voltage: current absent.
// - Occurrence and restoration logged apart, time stamped.
// - Anomaly entries carry voltage, current, power factor.
// - Both aux supplies down: power off/on, no snapshot.
// - All voltages low: feeder failure, no snapshot.
// - Power and feeder events record total duration.
// - Store keeps latest 350 events, first in first out.
// - Compartments of 100, 100, 100 and 50 events.
// - Full compartment overwrites only its own oldest.
// - Conditions except power off/on must persist five minutes both ways.
// - Counter counts occurrences only, readable outside.
////////////////////////////////////////////////////////////////////////

module mael_top import mael_pkg::*; #(
	parameter longint unsigned PERSIST_CYC = 64'(`MAEL_PERSIST_MIN)
		* 64'(`MAEL_SEC_PER_MIN) * 64'(`MAEL_CLK_HZ),
	parameter int unsigned SEC_CYC = `MAEL_CLK_HZ,
	parameter logic [15:0] V_MISS_TH = `MAEL_V_MISS_TH,
	parameter logic [15:0] V_OK_TH = `MAEL_V_OK_TH,
	parameter logic [15:0] V_FEED_TH = `MAEL_V_FEED_TH,
	parameter logic [15:0] V_UNB_TH = `MAEL_V_UNB_TH,
	parameter logic [15:0] I_MIN_TH = `MAEL_I_MIN_TH,
	parameter logic [15:0] I_UNB_TH = `MAEL_I_UNB_TH
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Phase quantities from the measurement front end.
	input wire mael_tri_t v_ph,
	input wire mael_tri_t i_ph,
	input wire mael_tri_t pf_ph,
	input wire logic [2:0] rev_ph,
	// Auxiliary supply sense pins, high while the supply is present.
	input wire logic [1:0] aux_ok,
	// Real-time clock and transaction events.
	input wire logic [31:0] rtc_time,
	input wire logic txn_evt,
	input wire logic [31:0] txn_code,
	// Log readout.
	input wire logic rd_req,
	input wire logic [1:0] rd_comp,
	input wire logic [6:0] rd_idx,
	output logic rd_valid,
	output logic rd_err,
	output mael_entry_t rd_data,
	// Status.
	output logic [31:0] anomaly_count,
	output logic [3:0][6:0] fill_level,
	output logic [6:0] anomaly_active
);

	localparam int EW = $bits(mael_entry_t);
	localparam logic [`MAEL_PCNT_W-1:0] PLIM =
		`MAEL_PCNT_W'(PERSIST_CYC - 64'd1);
	localparam logic [`MAEL_SEC_W-1:0] SLIM = `MAEL_SEC_W'(SEC_CYC - 1);

	// Refuse counts that the counters cannot hold.
	if (PERSIST_CYC < 64'd1 || PERSIST_CYC > (64'd1 << `MAEL_PCNT_W))
	begin : g_chk_p
		$error("mael_top: PERSIST_CYC out of range");
	end
	if (SEC_CYC < 1 || SEC_CYC > (1 << `MAEL_SEC_W)) begin : g_chk_s
		$error("mael_top: SEC_CYC out of range");
	end

	mael_state_t s_q;
	mael_state_t s_d;
	logic wr_en;
	logic [8:0] wr_addr;
	mael_entry_t wr_ent;
	logic [8:0] rd_addr;
	mael_entry_t ram_q;

	// Largest of three phase words.
	function automatic logic [15:0] mx3(input mael_tri_t x);
		logic [15:0] m;
		m = (x[0] > x[1]) ? x[0] : x[1];
		mx3 = (m > x[2]) ? m : x[2];
	endfunction

	// Smallest of three phase words.
	function automatic logic [15:0] mn3(input mael_tri_t x);
		logic [15:0] m;
		m = (x[0] < x[1]) ? x[0] : x[1];
		mn3 = (m < x[2]) ? m : x[2];
	endfunction

	////////////////////////////////////////////////////////////////////
	// Event store.
	mael_log_ram #(
		.DEPTH(`MAEL_DEPTH),
		.AW(`MAEL_ADDR_W),
		.W(EW)
	) u_ram (
		.mclk(mclk),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_ent),
		.rd_addr(rd_addr),
		.rd_data(ram_q)
	);

	////////////////////////////////////////////////////////////////////
	// Detection, persistence, arbitration, store and readout.
	always_comb begin
		logic [`MAEL_NQUAL-1:0] raw;
		logic [2:0] ilive;
		logic [2:0] lowv;
		logic [2:0] iabs;
		logic [2:0] vfeed;
		logic vgood;
		logic [`MAEL_NKIND-1:0] new_occ;
		logic [`MAEL_NKIND-1:0] new_rst;
		logic [`MAEL_NKIND-1:0] grant;
		logic [`MAEL_PCNT_W-1:0] lim;
		logic tick;
		logic found;
		logic is_occ;
		mael_kind_t sel;
		logic [1:0] wc;
		logic [8:0] cap;
		logic [8:0] t;
		raw = '0;
		ilive = '0;
		lowv = '0;
		iabs = '0;
		vfeed = '0;
		vgood = 1'b1;
		new_occ = '0;
		new_rst = '0;
		grant = '0;
		lim = '0;
		found = 1'b0;
		is_occ = 1'b0;
		sel = MAEL_K_MISSPOT;
		tick = 1'b0;
		wc = 2'h0;
		cap = '0;
		t = '0;
		wr_ent = '0;
		s_d = s_q;

		// Two-flop synchroniser on the supply sense pins.
		s_d.aux_s1 = aux_ok;
		s_d.aux_s2 = s_q.aux_s1;

		// Per-phase conditions.
		for (int p = 0; p < 3; p++) begin
			ilive[p] = i_ph[p] > I_MIN_TH;
			lowv[p] = (v_ph[p] < V_MISS_TH) && ilive[p];
			iabs[p] = (i_ph[p] < I_MIN_TH) && (v_ph[p] > V_OK_TH);
			vfeed[p] = v_ph[p] < V_FEED_TH;
			vgood = vgood && (v_ph[p] >= V_MISS_TH);
		end

		// Raw anomaly conditions, thresholds are parameters.
		raw[MAEL_K_MISSPOT] = (|lowv) && (lowv != 3'h7);
		raw[MAEL_K_REV] = |(rev_ph & ilive);
		raw[MAEL_K_VUNB] = (mx3(v_ph) - mn3(v_ph)) > V_UNB_TH;
		raw[MAEL_K_IUNB] = vgood && (|ilive)
			&& ((mx3(i_ph) - mn3(i_ph)) > I_UNB_TH);
		raw[MAEL_K_IABS] = |iabs;
		raw[MAEL_K_FEED] = &vfeed;
		raw[MAEL_K_PWR] = ~|s_q.aux_s2;

		// Persistence filter; a change must hold for the full time, except power off/on, which changes at once.
		for (int k = 0; k < `MAEL_NQUAL; k++) begin
			lim = (k == int'(MAEL_K_PWR)) ? '0 : PLIM;
			if (raw[k] == s_q.qual[k]) begin
				s_d.pcnt[k] = '0;
			end else if (s_q.pcnt[k] == lim) begin
				s_d.pcnt[k] = '0;
				s_d.qual[k] = raw[k];
				new_occ[k] = raw[k];
				new_rst[k] = ~raw[k];
				if (raw[k]) begin
					s_d.ts_occ[k] = rtc_time;
				end else begin
					s_d.ts_rst[k] = rtc_time;
				end
			end else begin
				s_d.pcnt[k] = s_q.pcnt[k] + 1'b1;
			end
		end

		// Transaction changes are logged at once.
		new_occ[MAEL_K_TXN] = txn_evt;
		if (txn_evt) begin
			s_d.ts_occ[MAEL_K_TXN] = rtc_time;
			s_d.txn_code = txn_code;
		end

		// Seconds base and outage duration counters.
		tick = s_q.sec_div == SLIM;
		s_d.sec_div = tick ? '0 : s_q.sec_div + 1'b1;
		for (int j = 0; j < 2; j++) begin
			if (new_occ[int'(MAEL_K_FEED) + j]) begin
				s_d.dur[j] = '0;
			end else if (s_q.qual[int'(MAEL_K_FEED) + j] && tick) begin
				s_d.dur[j] = s_q.dur[j] + 1'b1;
			end
		end

		// Lowest pending kind wins; occurrence before restoration.
		for (int k = `MAEL_NKIND - 1; k >= 0; k--) begin
			if (s_q.pend_occ[k] || s_q.pend_rst[k]) begin
				found = 1'b1;
				sel = mael_kind_t'(k);
			end
		end
		if (found) begin
			is_occ = s_q.pend_occ[sel];
			grant[sel] = 1'b1;
		end

		// Build the entry for the granted event.
		wr_ent.kind = sel;
		wr_ent.restore = ~is_occ;
		wr_ent.snap_ok = sel <= MAEL_K_IABS;
		wr_ent.ts = is_occ ? s_q.ts_occ[sel] : s_q.ts_rst[sel];
		case (sel)
			MAEL_K_FEED: wr_ent.dur = is_occ ? '0 : s_q.dur[0];
			MAEL_K_PWR: wr_ent.dur = is_occ ? '0 : s_q.dur[1];
			MAEL_K_TXN: wr_ent.dur = s_q.txn_code;
			default: wr_ent.dur = '0;
		endcase
		if (wr_ent.snap_ok) begin
			wr_ent.v = v_ph;
			wr_ent.i = i_ph;
			wr_ent.pf = pf_ph;
		end

		// Circular write into the event's own compartment.
		wc = mael_comp(sel);
		cap = mael_cap(wc);
		wr_en = found;
		wr_addr = mael_base(wc) + 9'(s_q.wp[wc]);
		if (found) begin
			if (9'(s_q.wp[wc]) == cap - 9'h1) begin
				s_d.wp[wc] = '0;
			end else begin
				s_d.wp[wc] = s_q.wp[wc] + 1'b1;
			end
			if (9'(s_q.fill[wc]) != cap) begin
				s_d.fill[wc] = s_q.fill[wc] + 1'b1;
			end
			if (is_occ && sel != MAEL_K_TXN) begin
				s_d.occ_cnt = s_q.occ_cnt + 1'b1;
			end
		end

		// Pending flags: a new event wins over the grant clear.
		s_d.pend_occ = (s_q.pend_occ & ~(grant & {8{is_occ}})) | new_occ;
		s_d.pend_rst = (s_q.pend_rst & ~(grant & {8{~is_occ}})) | new_rst;

		// Readout address, oldest entry at index zero.
		cap = mael_cap(rd_comp);
		t = 9'(s_q.wp[rd_comp]) + cap - 9'(s_q.fill[rd_comp])
			+ 9'(rd_idx);
		if (t >= cap) begin
			t = t - cap;
		end
		rd_addr = mael_base(rd_comp) + t;

		// Two-stage read answer.
		s_d.rd_pend = rd_req;
		s_d.rd_bad = rd_idx >= s_q.fill[rd_comp];
		s_d.rd_valid = s_q.rd_pend;
		s_d.rd_err = s_q.rd_pend && s_q.rd_bad;
		if (s_q.rd_pend) begin
			s_d.rd_data = s_q.rd_bad ? '0 : ram_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			// Supplies count as present, so a release logs no false outage.
			s_q.aux_s1 <= 2'h3;
			s_q.aux_s2 <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register.
	assign rd_valid = s_q.rd_valid;
	assign rd_err = s_q.rd_err;
	assign rd_data = s_q.rd_data;
	assign anomaly_count = s_q.occ_cnt;
	assign fill_level = s_q.fill;
	assign anomaly_active = s_q.qual;

endmodule // mael_top

// ---- tb/mael_top_assertions.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// Port-level checker for the anomaly logger.
module mael_top_chk import mael_pkg::*; #(
	parameter longint unsigned PERSIST_CYC = 20
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Stimulus seen at the inputs.
	input wire logic [1:0] aux_ok,
	input wire logic txn_evt,
	input wire logic rd_req,
	// Outputs under watch.
	input wire logic rd_valid,
	input wire logic rd_err,
	input wire mael_entry_t rd_data,
	input wire logic [31:0] anomaly_count,
	input wire logic [3:0][6:0] fill_level,
	input wire logic [6:0] anomaly_active
);
	logic act_q;
	logic [7:0] age_q;

	// Edges since the missing potential state last flipped.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			act_q <= 1'b0;
			age_q <= 8'h0;
		end else begin
			act_q <= anomaly_active[0];
			if (anomaly_active[0] != act_q) begin
				age_q <= 8'h0;
			end else if (age_q != 8'hff) begin
				age_q <= age_q + 8'h1;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// A read request, and both supplies gone long enough to pass sync.
	sequence rd_taken;
		rd_req;
	endsequence
	sequence aux_down;
		(aux_ok == 2'h0) [*7];
	endsequence

	rd_ans_a: assert property (rd_taken |-> ##2 rd_valid)
		else $error("read answer not two cycles after request");
	rd_cause_a: assert property (rd_valid |-> $past(rd_req, 2))
		else $error("read answer without request");
	err_zero_a: assert property (rd_err |-> rd_valid && rd_data == '0)
		else $error("refused read not zero");
	cnt_step_a: assert property ($changed(anomaly_count) |->
		anomaly_count == $past(anomaly_count) + 32'h1)
		else $error("anomaly count jumped");
	fill_cap_a: assert property (fill_level[3] <= 7'd50 &&
		fill_level[0] <= 7'd100 && fill_level[2] <= 7'd100)
		else $error("compartment over capacity");
	fill_grow_a: assert property ($changed(fill_level[3]) |->
		fill_level[3] == $past(fill_level[3]) + 7'h1)
		else $error("transaction fill level stepped wrongly");
	persist_hold_a: assert property (anomaly_active[0] != act_q |->
		{56'h0, age_q} + 64'd2 >= PERSIST_CYC)
		else $error("state flipped before persistence time");
	occ_count_a: assert property ($rose(anomaly_active[0]) |->
		##[1:17] $changed(anomaly_count))
		else $error("occurrence not counted");
	pwr_off_a: assert property (aux_down |-> anomaly_active[6])
		else $error("power off not flagged");
	txn_log_a: assert property (txn_evt && fill_level[3] < 7'd50 |->
		##[1:17] $changed(fill_level[3]))
		else $error("transaction not logged");
endmodule // mael_top_chk

bind mael_top mael_top_chk #(.PERSIST_CYC(PERSIST_CYC)) u_chk (
	.mclk(mclk), .rst_n(rst_n), .aux_ok(aux_ok), .txn_evt(txn_evt),
	.rd_req(rd_req), .rd_valid(rd_valid), .rd_err(rd_err),
	.rd_data(rd_data), .anomaly_count(anomaly_count),
	.fill_level(fill_level), .anomaly_active(anomaly_active)
);

// ---- tb/mael_top_tb.sv ----
`timescale 1ns/10ps
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin err_total++; \
	$display("BAD t=%0t got %h exp %h", $time, (g), (x)); end end
////////////////////////////////////////////////////////////////////////
module mael_top_tb import mael_pkg::*; ;
	localparam int P = 20;
	localparam int W = P + 30;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	mael_tri_t v_ph, i_ph, pf_ph;
	logic [2:0] rev_ph;
	logic [1:0] aux_ok, rd_comp;
	logic [31:0] rtc_time = 32'h0;
	logic [31:0] txn_code, anomaly_count;
	logic txn_evt, rd_req, rd_valid, rd_err;
	logic [6:0] rd_idx, anomaly_active;
	logic [3:0][6:0] fill_level;
	mael_entry_t rd_data, e;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;

	mael_top #(.PERSIST_CYC(64'(P)), .SEC_CYC(4)) uut (
		.mclk(mclk), .rst_n(rst_n), .v_ph(v_ph), .i_ph(i_ph),
		.pf_ph(pf_ph), .rev_ph(rev_ph), .aux_ok(aux_ok),
		.rtc_time(rtc_time), .txn_evt(txn_evt), .txn_code(txn_code),
		.rd_req(rd_req), .rd_comp(rd_comp), .rd_idx(rd_idx),
		.rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data),
		.anomaly_count(anomaly_count), .fill_level(fill_level),
		.anomaly_active(anomaly_active)
	);

	// Clock, real-time clock and hang limit.
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		rtc_time <= rtc_time + 32'h1;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Reads one entry; the answer stands for one cycle after the second edge.
	task automatic rd(input logic [1:0] c, input logic [6:0] x);
		@(posedge mclk);
		rd_req <= 1'b1;
		rd_comp <= c;
		rd_idx <= x;
		@(posedge mclk);
		rd_req <= 1'b0;
		wt(1);
		`CHK(rd_valid, 1'b1)
		e = rd_data;
	endtask

	// A short dip is ignored, a held one logs occurrence and restoration.
	task automatic t_miss();
		@(posedge mclk) v_ph[0] <= 16'h1800;
		repeat (P / 2) @(posedge mclk);
		v_ph[0] <= 16'h8000;
		wt(W);
		`CHK(fill_level[0], 7'h0)
		@(posedge mclk) v_ph[0] <= 16'h1800;
		wt(W);
		`CHK(anomaly_active[1:0], 2'h3)
		`CHK(anomaly_count, 32'h2)
		rd(2'h0, 7'h0);
		`CHK({e.kind, e.restore, e.snap_ok}, {MAEL_K_MISSPOT, 2'h1})
		`CHK({e.v[0], e.pf[2]}, 32'h18001234)
		@(posedge mclk) v_ph[0] <= 16'h8000;
		wt(W);
		`CHK(anomaly_count, 32'h2)
		`CHK(fill_level[0], 7'h4)
		rd(2'h0, 7'h2);
		`CHK({e.kind, e.restore}, {MAEL_K_MISSPOT, 1'b1})
		$display("missing potential test done");
	endtask

	// Two phases with swapped current terminals.
	task automatic t_rev();
		@(posedge mclk) rev_ph <= 3'h3;
		wt(W);
		rd(2'h1, 7'h0);
		`CHK(e.kind, MAEL_K_REV)
		@(posedge mclk) rev_ph <= 3'h0;
		wt(W);
		`CHK(anomaly_count, 32'h3)
		`CHK(fill_level[1], 7'h2)
		$display("reversal test done");
	endtask

	// All phases low: feeder failure without snapshot, with duration.
	task automatic t_feed();
		@(posedge mclk) v_ph <= {3{16'h0800}};
		wt(W);
		`CHK(anomaly_active[5:0], 6'h20)
		rd(2'h2, 7'h0);
		`CHK({e.kind, e.snap_ok, e.v}, {MAEL_K_FEED, 49'h0})
		@(posedge mclk) v_ph <= {3{16'h8000}};
		wt(W);
		rd(2'h2, 7'h1);
		`CHK({e.restore, e.dur == 32'h0}, 2'h2)
		$display("feeder test done");
	endtask

	// One supply alone is no outage; both down logs off and on.
	task automatic t_pwr();
		@(posedge mclk) aux_ok <= 2'h1;
		wt(P);
		`CHK(anomaly_active[6], 1'b0)
		@(posedge mclk) aux_ok <= 2'h0;
		wt(W);
		`CHK(anomaly_count, 32'h5)
		@(posedge mclk) aux_ok <= 2'h3;
		wt(W);
		rd(2'h2, 7'h2);
		`CHK({e.kind, e.restore, e.snap_ok, e.dur}, {MAEL_K_PWR, 34'h0})
		rd(2'h2, 7'h3);
		`CHK({e.restore, e.snap_ok, e.i}, {2'h2, 48'h0})
		`CHK(e.dur == 32'h0, 1'b0)
		$display("power test done");
	endtask

	// Overfill the transaction compartment by two entries.
	task automatic t_txn();
		for (int k = 0; k < 52; k++) begin
			@(posedge mclk);
			txn_evt <= 1'b1;
			txn_code <= 32'(k);
			@(posedge mclk);
			txn_evt <= 1'b0;
			repeat (18) @(posedge mclk);
		end
		wt(4);
		`CHK(fill_level, {7'd50, 7'd4, 7'd2, 7'd4})
		`CHK(anomaly_count, 32'h5)
		rd(2'h3, 7'h0);
		`CHK({e.kind, e.dur}, {MAEL_K_TXN, 32'h2})
		rd(2'h3, 7'd49);
		`CHK(e.dur, 32'd51)
		rd(2'h3, 7'd50);
		`CHK({rd_err, e}, {1'b1, 213'h0})
		$display("transaction test done");
	endtask

	// One dead phase current and a wide current spread.
	task automatic t_cur();
		@(posedge mclk) i_ph <= {16'h0800, 16'h0200, 16'h0050};
		wt(W);
		`CHK(anomaly_active[4:3], 2'h3)
		`CHK(anomaly_count, 32'h7)
		rd(2'h1, 7'h3);
		`CHK({e.kind, e.i[0]}, {MAEL_K_IABS, 16'h0050})
		@(posedge mclk) i_ph <= {3{16'h0200}};
		wt(W);
		`CHK({anomaly_count, fill_level[1]}, {32'h7, 7'h6})
		$display("current test done");
	endtask

	// Reset in mid-run clears counts and empties every compartment.
	task automatic t_rst();
		@(posedge mclk) rst_n <= 1'b0;
		wt(2);
		`CHK({anomaly_count, fill_level, anomaly_active}, 67'h0)
		@(posedge mclk) rst_n <= 1'b1;
		rd(2'h3, 7'h0);
		`CHK(rd_err, 1'b1)
		$display("reset test done");
	endtask

	////////////////////////////////////////////////////////////////////
	// Quiet balanced system, reset, then the scenarios.
	initial begin
		v_ph = {3{16'h8000}};
		i_ph = {3{16'h0200}};
		pf_ph = {3{16'h1234}};
		rev_ph = 3'h0;
		aux_ok = 2'h3;
		txn_evt = 1'b0;
		txn_code = 32'h0;
		rd_req = 1'b0;
		rd_comp = 2'h0;
		rd_idx = 7'h0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		t_miss();
		t_rev();
		t_feed();
		t_pwr();
		t_txn();
		t_cur();
		t_rst();
		end_sim();
	end
endmodule // mael_top_tb
